// ==== rtl/crc_pkg.sv ====
package crc_pkg;

    // role register
    localparam logic [7:0] CMD_REDUNDANCY_ROLE = 8'hd0;
    localparam logic [7:0] ROLE_STANDARD = 8'h00;
    localparam logic [7:0] ROLE_ACTIVE = 8'h01;
    localparam logic [7:0] ROLE_STBY1 = 8'h02;
    localparam logic [7:0] ROLE_STBY2 = 8'h03;
    localparam logic [7:0] ROLE_STBY3 = 8'h04;
    localparam logic [7:0] ROLE_RESET = ROLE_STANDARD;

    // smbus framing
    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h58;
    localparam logic [7:0] PEC_POLY = 8'h07;
    localparam logic [7:0] PEC_INIT = 8'h00;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_DONE = 4'h9;

    // load-share sample scale: 8-bit code, full scale in millivolts
    localparam int SHARE_FULL_MV = 8000;
    localparam int SHARE_CODES = 256;
    localparam int EN_MV_1 = 3200;
    localparam int EN_MV_2 = 5000;
    localparam int EN_MV_3 = 6700;
    localparam int DIS_MV_1 = 1440;
    localparam int DIS_MV_2 = 3010;
    localparam int DIS_MV_3 = 4520;

    function automatic logic [7:0] mv_to_code(input int mv);
        return 8'(mv * SHARE_CODES / SHARE_FULL_MV);
    endfunction

    localparam logic [7:0] EN_CODE_1 = mv_to_code(EN_MV_1);
    localparam logic [7:0] EN_CODE_2 = mv_to_code(EN_MV_2);
    localparam logic [7:0] EN_CODE_3 = mv_to_code(EN_MV_3);
    localparam logic [7:0] DIS_CODE_1 = mv_to_code(DIS_MV_1);
    localparam logic [7:0] DIS_CODE_2 = mv_to_code(DIS_MV_2);
    localparam logic [7:0] DIS_CODE_3 = mv_to_code(DIS_MV_3);

    typedef enum logic [2:0] {
        PH_IDLE   = 3'b000,
        PH_ADDR   = 3'b001,
        PH_CMD    = 3'b010,
        PH_WDATA  = 3'b011,
        PH_WPEC   = 3'b100,
        PH_RDATA  = 3'b101,
        PH_RPEC   = 3'b110,
        PH_IGNORE = 3'b111
    } crc_phase_e;

    function automatic logic is_standby_role(input logic [7:0] role);
        return (role == ROLE_STBY1) || (role == ROLE_STBY2) ||
               (role == ROLE_STBY3);
    endfunction

    function automatic logic [7:0] pec_update(input logic [7:0] acc,
                                              input logic [7:0] data);
        logic [7:0] c;
        c = acc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ PEC_POLY) : (c << 1);
        end
        return c;
    endfunction

endpackage

// ==== rtl/crc_share_cmp.sv ====
`timescale 1ns/1ps
`default_nettype none
module crc_share_cmp
    import crc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic [7:0] role_in,
    input wire logic [7:0] sample_in,
    input wire logic valid_in,
    output logic share_on_out
);

    logic [7:0] en_thr;
    logic [7:0] dis_thr;

    // thresholds indexed by standby position
    always_comb begin
        unique case (role_in)
            ROLE_STBY2: begin
                en_thr = EN_CODE_2;
                dis_thr = DIS_CODE_2;
            end
            ROLE_STBY3: begin
                en_thr = EN_CODE_3;
                dis_thr = DIS_CODE_3;
            end
            default: begin
                en_thr = EN_CODE_1;
                dis_thr = DIS_CODE_1;
            end
        endcase
    end

    // hysteresis: on above enable level, off below the lower one
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            share_on_out <= 1'b0;
        end else if (!enable_in) begin
            share_on_out <= 1'b0;
        end else if (valid_in) begin
            if (!share_on_out && sample_in > en_thr) begin
                share_on_out <= 1'b1;
            end else if (share_on_out && sample_in < dis_thr) begin
                share_on_out <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ==== rtl/crc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module crc_top
    import crc_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT
) (
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N_OUT,
    input wire logic POWER_ON_REQUEST_N_IN,
    input wire logic COLD_RED_ENABLE_N_IN,
    input wire logic UNIT_FAULT_IN,
    input wire logic VOUT_LOW_IN,
    input wire logic OUTPUT_OK_IN,
    input wire logic [7:0] SHARE_SAMPLE_IN,
    input wire logic SHARE_VALID_IN,
    input wire logic SHARED_WAKE_LINE_IN,
    output logic SHARED_WAKE_LINE_OUT,
    output logic SHARED_WAKE_LINE_OE_N_OUT,
    output logic MAIN_ON_OUT,
    output logic ISOLATION_ON_OUT,
    output logic POWER_GOOD_OUT,
    output logic DUMMY_LOAD_EN_OUT,
    output logic FAN_EN_OUT,
    output logic SLOW_START_EN_OUT,
    output logic LOOP_PRESET_MAX_OUT,
    output logic STATUS_REPORT_EN_OUT,
    output logic COLD_STANDBY_OUT,
    output logic [7:0] ROLE_OUT
);

    logic rst_meta;
    logic rst_n;

    // reset released through two flops, asserted at once
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // smbus bit engine
    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic tx_phase;
    crc_phase_e phase;
    crc_phase_e pend;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [7:0] pec;
    logic [7:0] wr_data;
    logic cmd_ok;
    logic drive_low;
    logic role_wr;
    logic [7:0] role;

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= SCL_IN;
            sda_d <= SDA_IN;
        end
    end

    assign scl_rise = SCL_IN & ~scl_d;
    assign scl_fall = ~SCL_IN & scl_d;
    assign start_det = scl_d & SCL_IN & sda_d & ~SDA_IN;
    assign stop_det = scl_d & SCL_IN & ~sda_d & SDA_IN;
    assign tx_phase = (phase == PH_RDATA) || (phase == PH_RPEC);

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            phase <= PH_IDLE;
            pend <= PH_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            tx <= 8'h00;
            pec <= PEC_INIT;
            wr_data <= 8'h00;
            cmd_ok <= 1'b0;
            drive_low <= 1'b0;
            role_wr <= 1'b0;
        end else begin
            role_wr <= 1'b0;
            if (stop_det) begin
                phase <= PH_IDLE;
                drive_low <= 1'b0;
                cmd_ok <= 1'b0;
            end else if (start_det) begin
                // sr after the command keeps the pec; its rise looks a bit
                phase <= PH_ADDR;
                bit_cnt <= 4'h0;
                drive_low <= 1'b0;
                if (phase != PH_WDATA || bit_cnt > 4'h1) begin
                    cmd_ok <= 1'b0;
                    pec <= PEC_INIT;
                end
            end else if (phase != PH_IDLE && phase != PH_IGNORE) begin
                if (scl_rise) begin
                    if (bit_cnt < BIT_ACK) begin
                        shift <= {shift[6:0], SDA_IN};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (bit_cnt == BIT_ACK) begin
                        bit_cnt <= BIT_DONE;
                        // master nack ends a read
                        if (tx_phase && SDA_IN) begin
                            phase <= PH_IGNORE;
                        end
                    end
                end else if (scl_fall) begin
                    if (bit_cnt == BIT_ACK) begin
                        if (tx_phase) begin
                            drive_low <= 1'b0;
                            if (phase == PH_RDATA) begin
                                pec <= pec_update(pec, tx);
                                tx <= pec_update(pec, tx);
                                pend <= PH_RPEC;
                            end else begin
                                pend <= PH_IGNORE;
                            end
                        end else begin
                            unique case (phase)
                                PH_ADDR: begin
                                    if (shift[7:1] == SLAVE_ADDR &&
                                        (!shift[0] || cmd_ok)) begin
                                        drive_low <= 1'b1;
                                        pec <= pec_update(pec, shift);
                                        tx <= role;
                                        pend <= shift[0] ? PH_RDATA : PH_CMD;
                                    end else begin
                                        pend <= PH_IGNORE;
                                    end
                                end
                                PH_CMD: begin
                                    // only the role command is answered
                                    if (shift == CMD_REDUNDANCY_ROLE) begin
                                        drive_low <= 1'b1;
                                        cmd_ok <= 1'b1;
                                        pec <= pec_update(pec, shift);
                                        pend <= PH_WDATA;
                                    end else begin
                                        pend <= PH_IGNORE;
                                    end
                                end
                                PH_WDATA: begin
                                    drive_low <= 1'b1;
                                    wr_data <= shift;
                                    pec <= pec_update(pec, shift);
                                    pend <= PH_WPEC;
                                end
                                PH_WPEC: begin
                                    // commit needs a good pec and a legal role
                                    if (shift == pec &&
                                        wr_data <= ROLE_STBY3) begin
                                        drive_low <= 1'b1;
                                        role_wr <= 1'b1;
                                    end
                                    pend <= PH_IGNORE;
                                end
                                default: begin
                                    pend <= PH_IGNORE;
                                end
                            endcase
                        end
                    end else if (bit_cnt == BIT_DONE) begin
                        phase <= pend;
                        bit_cnt <= 4'h0;
                        drive_low <= (pend == PH_RDATA || pend == PH_RPEC) ?
                                     ~tx[7] : 1'b0;
                    end else if (tx_phase && bit_cnt != 4'h0) begin
                        drive_low <= ~tx[3'(4'h7 - bit_cnt)];
                    end
                end
            end
        end
    end

    assign SDA_OUT = 1'b0;
    assign SDA_OE_N_OUT = ~drive_low;

    // role register; wake-line revert beats a same-cycle write
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            role <= ROLE_RESET;
        end else if (!SHARED_WAKE_LINE_IN && is_standby_role(role)) begin
            role <= ROLE_STANDARD;
        end else if (role_wr) begin
            role <= wr_data;
        end
    end

    // operating state
    logic power_req;
    logic stby_cfg;
    logic share_on;
    logic cold_standby;
    logic main_on;
    logic fault;

    assign power_req = ~POWER_ON_REQUEST_N_IN;
    assign stby_cfg = power_req & COLD_RED_ENABLE_N_IN &
                      is_standby_role(role);
    assign fault = UNIT_FAULT_IN | VOUT_LOW_IN;

    // a standby unit leaves standby on its own compare, a low wake line or a role write
    crc_share_cmp u_share_cmp (
        .clk_in(CLK_IN),
        .rst_n_in(rst_n),
        .enable_in(stby_cfg),
        .role_in(role),
        .sample_in(SHARE_SAMPLE_IN),
        .valid_in(SHARE_VALID_IN),
        .share_on_out(share_on)
    );

    // roles 00 and 01 ignore the share compare and stay on
    assign cold_standby = stby_cfg & ~share_on &
                          SHARED_WAKE_LINE_IN;
    assign main_on = power_req & ~cold_standby;

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            MAIN_ON_OUT <= 1'b0;
            ISOLATION_ON_OUT <= 1'b0;
            POWER_GOOD_OUT <= 1'b0;
            DUMMY_LOAD_EN_OUT <= 1'b0;
            FAN_EN_OUT <= 1'b0;
            SLOW_START_EN_OUT <= 1'b0;
            LOOP_PRESET_MAX_OUT <= 1'b0;
            STATUS_REPORT_EN_OUT <= 1'b0;
            COLD_STANDBY_OUT <= 1'b0;
        end else begin
            MAIN_ON_OUT <= main_on;
            ISOLATION_ON_OUT <= main_on;
            POWER_GOOD_OUT <= cold_standby |
                              (main_on & OUTPUT_OK_IN);
            DUMMY_LOAD_EN_OUT <= main_on;
            FAN_EN_OUT <= ~cold_standby;
            // preset loop so a wake-up is not held back by compensation
            SLOW_START_EN_OUT <= ~cold_standby;
            LOOP_PRESET_MAX_OUT <= cold_standby;
            STATUS_REPORT_EN_OUT <= ~cold_standby;
            COLD_STANDBY_OUT <= cold_standby;
        end
    end

    // wake line: fault pulls low, active role drives high, else released
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            SHARED_WAKE_LINE_OUT <= 1'b0;
            SHARED_WAKE_LINE_OE_N_OUT <= 1'b1;
        end else if (fault) begin
            SHARED_WAKE_LINE_OUT <= 1'b0;
            SHARED_WAKE_LINE_OE_N_OUT <= 1'b0;
        end else if (role == ROLE_ACTIVE) begin
            SHARED_WAKE_LINE_OUT <= 1'b1;
            SHARED_WAKE_LINE_OE_N_OUT <= 1'b0;
        end else begin
            SHARED_WAKE_LINE_OUT <= 1'b0;
            SHARED_WAKE_LINE_OE_N_OUT <= 1'b1;
        end
    end

    assign ROLE_OUT = role;

endmodule
`default_nettype wire

// ==== bench/crc_peer_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module crc_peer_model (
    input wire logic dut_wake_in,
    input wire logic dut_wake_oe_n_in,
    input wire logic [1:0] peer_drive_in,
    input wire logic host_sda_in,
    input wire logic dut_sda_in,
    input wire logic dut_sda_oe_n_in,
    output logic wake_out,
    output logic sda_out
);
    // peer drive: 0 released, 1 high, 2 low (a faulty peer)
    logic lo;
    logic hi;
    assign lo = (!dut_wake_oe_n_in && !dut_wake_in) || peer_drive_in[1];
    assign hi = (!dut_wake_oe_n_in && dut_wake_in) || peer_drive_in[0];
    // low wins; a released line rests on its weak pull-down
    assign wake_out = !lo && hi;
    assign sda_out = host_sda_in && (dut_sda_oe_n_in || dut_sda_in);
endmodule
`default_nettype wire

// ==== bench/crc_top_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module crc_top_asserts
    import crc_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic POWER_ON_REQUEST_N_IN,
    input wire logic COLD_RED_ENABLE_N_IN,
    input wire logic UNIT_FAULT_IN,
    input wire logic VOUT_LOW_IN,
    input wire logic SHARED_WAKE_LINE_IN,
    input wire logic SHARED_WAKE_LINE_OUT,
    input wire logic SHARED_WAKE_LINE_OE_N_OUT,
    input wire logic MAIN_ON_OUT,
    input wire logic ISOLATION_ON_OUT,
    input wire logic POWER_GOOD_OUT,
    input wire logic DUMMY_LOAD_EN_OUT,
    input wire logic FAN_EN_OUT,
    input wire logic SLOW_START_EN_OUT,
    input wire logic LOOP_PRESET_MAX_OUT,
    input wire logic STATUS_REPORT_EN_OUT,
    input wire logic COLD_STANDBY_OUT,
    input wire logic [7:0] ROLE_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    logic sb;
    assign sb = ROLE_OUT inside {ROLE_STBY1, ROLE_STBY2, ROLE_STBY3};
    property p_enter;
        COLD_STANDBY_OUT |-> $past(sb && COLD_RED_ENABLE_N_IN) &&
            $past(!POWER_ON_REQUEST_N_IN);
    endproperty
    a_enter: assert property (p_enter) else $error("bad standby");
    property p_wake_on;
        COLD_STANDBY_OUT && !SHARED_WAKE_LINE_IN |-> ##[1:2] MAIN_ON_OUT;
    endproperty
    a_wake_on: assert property (p_wake_on) else $error("no wake");
    property p_iso;
        COLD_STANDBY_OUT |-> !ISOLATION_ON_OUT && POWER_GOOD_OUT;
    endproperty
    a_iso: assert property (p_iso) else $error("iso or pg");
    property p_quiet;
        COLD_STANDBY_OUT |-> !DUMMY_LOAD_EN_OUT && !FAN_EN_OUT;
    endproperty
    a_quiet: assert property (p_quiet) else $error("load or fan");
    property p_fast;
        COLD_STANDBY_OUT |-> !SLOW_START_EN_OUT && LOOP_PRESET_MAX_OUT &&
            !STATUS_REPORT_EN_OUT;
    endproperty
    a_fast: assert property (p_fast) else $error("start cfg");
    property p_revert;
        sb && !SHARED_WAKE_LINE_IN |=> ROLE_OUT == ROLE_STANDARD;
    endproperty
    a_revert: assert property (p_revert) else $error("no revert");
    property p_fault;
        (UNIT_FAULT_IN || VOUT_LOW_IN) && $past(ARST_N_IN, 3)
            |=> !SHARED_WAKE_LINE_OE_N_OUT && !SHARED_WAKE_LINE_OUT;
    endproperty
    a_fault: assert property (p_fault)
        else $error("wake not low");
    property p_active;
        ROLE_OUT == ROLE_ACTIVE && !UNIT_FAULT_IN && !VOUT_LOW_IN &&
            !POWER_ON_REQUEST_N_IN
            |=> MAIN_ON_OUT && SHARED_WAKE_LINE_OUT &&
            !SHARED_WAKE_LINE_OE_N_OUT;
    endproperty
    a_active: assert property (p_active)
        else $error("active role");
endmodule
bind crc_top crc_top_asserts crc_top_asserts_inst (
    .CLK_IN, .ARST_N_IN, .POWER_ON_REQUEST_N_IN, .COLD_RED_ENABLE_N_IN,
    .UNIT_FAULT_IN, .VOUT_LOW_IN, .SHARED_WAKE_LINE_IN, .SHARED_WAKE_LINE_OUT,
    .SHARED_WAKE_LINE_OE_N_OUT, .MAIN_ON_OUT, .ISOLATION_ON_OUT,
    .POWER_GOOD_OUT, .DUMMY_LOAD_EN_OUT, .FAN_EN_OUT, .SLOW_START_EN_OUT,
    .LOOP_PRESET_MAX_OUT, .STATUS_REPORT_EN_OUT, .COLD_STANDBY_OUT, .ROLE_OUT
);
`default_nettype wire

// ==== bench/test_cold_redundancy_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_cold_redundancy_control
    import crc_pkg::*;
;
    localparam logic [7:0] AW = {SLAVE_ADDR_DEFAULT, 1'b0};
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic scl = 1'b1;
    logic sda_m = 1'b1;
    logic pwr_n = 1'b1;
    logic cre_n = 1'b1;
    logic fault = 1'b0;
    logic vlow = 1'b0;
    logic [7:0] smp = 8'h00;
    logic smp_v = 1'b0;
    logic ok = 1'b1;
    logic [1:0] peer = 2'd1;
    logic sda, sda_o, sda_oe_n, wake, wake_o, wake_oe_n, ack;
    logic cold, main_on, iso, pgood, dummy, fan, slow, lmax, stat;
    logic [7:0] role;
    logic [8:0] outs;
    int en_mv [3] = '{3200, 5000, 6700};
    int dis_mv [3] = '{1440, 3010, 4520};
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    assign outs = {cold, main_on, iso, pgood, dummy, fan, slow, lmax, stat};
    crc_top crc_top_inst (.CLK_IN(clk), .ARST_N_IN(arst_n), .SCL_IN(scl),
        .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_N_OUT(sda_oe_n),
        .POWER_ON_REQUEST_N_IN(pwr_n), .COLD_RED_ENABLE_N_IN(cre_n),
        .UNIT_FAULT_IN(fault), .VOUT_LOW_IN(vlow), .OUTPUT_OK_IN(ok),
        .SHARE_SAMPLE_IN(smp), .SHARE_VALID_IN(smp_v),
        .SHARED_WAKE_LINE_IN(wake), .SHARED_WAKE_LINE_OUT(wake_o),
        .SHARED_WAKE_LINE_OE_N_OUT(wake_oe_n), .MAIN_ON_OUT(main_on),
        .ISOLATION_ON_OUT(iso), .POWER_GOOD_OUT(pgood),
        .DUMMY_LOAD_EN_OUT(dummy), .FAN_EN_OUT(fan), .SLOW_START_EN_OUT(slow),
        .LOOP_PRESET_MAX_OUT(lmax), .STATUS_REPORT_EN_OUT(stat),
        .COLD_STANDBY_OUT(cold), .ROLE_OUT(role));
    crc_peer_model crc_peer_model_inst (.dut_wake_in(wake_o),
        .dut_wake_oe_n_in(wake_oe_n), .peer_drive_in(peer),
        .host_sda_in(sda_m), .dut_sda_in(sda_o), .dut_sda_oe_n_in(sda_oe_n),
        .wake_out(wake), .sda_out(sda));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // a whole run needs about 4700 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            results();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] crc8(input logic [7:0] a,
                                        input logic [7:0] d);
        logic [7:0] c;
        c = a ^ d;
        for (int i = 0; i < 8; i++)
            c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
        return c;
    endfunction
    // sda moves only while scl is low, except for start and stop
    task automatic sedge(input logic b1, input logic b2);
        scl = 1'b0;
        tick(1);
        sda_m = b1;
        tick(2);
        scl = 1'b1;
        tick(3);
        sda_m = b2;
        tick(3);
    endtask
    task automatic sbit(input logic b, output logic r);
        scl = 1'b0;
        tick(1);
        sda_m = b;
        tick(2);
        scl = 1'b1;
        tick(1);
        r = sda;
        tick(2);
    endtask
    task automatic sbyte(input logic [7:0] d, input logic m,
                         output logic [7:0] r, output logic ak);
        logic a;
        for (int i = 7; i >= 0; i--)
            sbit(d[i], r[i]);
        sbit(m, a);
        ak = !a;
    endtask
    task automatic wr_role(input logic [7:0] d, input logic [7:0] flip);
        logic [7:0] p, r;
        logic a;
        p = crc8(crc8(crc8(8'h00, AW), CMD_REDUNDANCY_ROLE), d) ^ flip;
        sedge(1'b1, 1'b0);
        sbyte(AW, 1'b1, r, a);
        sbyte(CMD_REDUNDANCY_ROLE, 1'b1, r, a);
        sbyte(d, 1'b1, r, a);
        sbyte(p, 1'b1, r, ack);
        sedge(1'b0, 1'b1);
    endtask
    task automatic rd_chk(input logic [7:0] exp);
        logic [7:0] v, p, r;
        logic a;
        sedge(1'b1, 1'b0);
        sbyte(AW, 1'b1, r, a);
        sbyte(CMD_REDUNDANCY_ROLE, 1'b1, r, a);
        sedge(1'b1, 1'b0);
        sbyte(AW | 8'h01, 1'b1, r, a);
        sbyte(8'hff, 1'b0, v, a);
        sbyte(8'hff, 1'b1, p, a);
        sedge(1'b0, 1'b1);
        chk({v, p}, {exp, crc8(crc8(crc8(crc8(8'h00, AW),
            CMD_REDUNDANCY_ROLE), AW | 8'h01), exp)});
    endtask
    task automatic share(input int mv, input int adj);
        smp = 8'(mv * SHARE_CODES / SHARE_FULL_MV + adj);
        smp_v = 1'b1;
        tick(1);
        smp_v = 1'b0;
        tick(2);
    endtask
    initial begin
        tick(4);
        arst_n = 1'b1;
        tick(4);
        chk(role, ROLE_RESET);
        rd_chk(ROLE_STANDARD);
        for (int v = 0; v < 5; v++) begin
            wr_role(8'(v), 8'h00);
            rd_chk(8'(v));
        end
        wr_role(8'h05, 8'h00);
        chk({ack, role}, {1'b0, ROLE_STBY3});
        wr_role(8'hff, 8'h00);
        chk({ack, role}, {1'b0, ROLE_STBY3});
        wr_role(ROLE_ACTIVE, 8'h01);
        chk({ack, role}, {1'b0, ROLE_STBY3});
        $display("test config done");
        pwr_n = 1'b0;
        cre_n = 1'b0;
        tick(2);
        chk(cold, 1'b0);
        cre_n = 1'b1;
        tick(2);
        chk(outs, 9'h122);
        chk(wake_oe_n, 1'b1);
        ok = 1'b0;
        tick(2);
        chk(pgood, 1'b1);
        ok = 1'b1;
        peer = 2'd2;
        tick(2);
        chk({main_on, role}, {1'b1, ROLE_STANDARD});
        chk(outs, 9'h0fd);
        peer = 2'd1;
        $display("test standby done");
        for (int k = 0; k < 3; k++) begin
            wr_role(ROLE_STBY1 + 8'(k), 8'h00);
            smp = 8'hff;
            tick(3);
            chk(cold, 1'b1);
            share(en_mv[k], 0);
            chk(main_on, 1'b0);
            share(en_mv[k], 1);
            chk({cold, main_on}, 2'b01);
            share(dis_mv[k], 0);
            chk(main_on, 1'b1);
            share(dis_mv[k], -1);
            chk({cold, main_on}, 2'b10);
        end
        $display("test thresholds done");
        fault = 1'b1;
        tick(2);
        chk({wake_oe_n, wake_o, main_on}, 3'b001);
        fault = 1'b0;
        vlow = 1'b1;
        tick(2);
        chk({wake_oe_n, wake_o}, 2'b00);
        vlow = 1'b0;
        tick(2);
        chk({wake_oe_n, role}, {1'b1, ROLE_STANDARD});
        wr_role(ROLE_ACTIVE, 8'h00);
        share(0, 0);
        chk({wake_oe_n, wake_o, main_on}, 3'b011);
        fault = 1'b1;
        tick(2);
        chk({wake_oe_n, wake_o}, 2'b00);
        fault = 1'b0;
        $display("test wake done");
        results();
    end
endmodule
`default_nettype wire
